/* logic/input_sync.sv */
// Two-stage synchroniser for a group of asynchronous contact inputs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module input_sync
  import light_trigger_pkg::*;
#(
  parameter int W = 5
)
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* logic/light_trigger_controller.sv */
// Lamp trigger controller: decodes contact triggers and drives four lamp channels.
// Assumes an AHB-Lite master on one 20 MHz clock and contacts that bounce asynchronously.
`timescale 1ns/1ps

// Summary of operation
// - open contact to common means trigger active
// - continuous mode follows network on/off setting
// - normal on follows trigger; reversed on stays lit
// - strobe flashes on active, reversed on inactive
// - polarity selectable normal or reversed, normal default
// - setting off in continuous mode: dark, reversed lit when inactive; strobe ignores the setting
// - exactly two modes, continuous and strobe
// - one trigger may drive all four channels together
// - trigger input N drives lamp N
module light_trigger_controller
  import light_trigger_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hsel,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [CH_COUNT-1:0] lamp_trigger_in,
  input  wire logic                lamp_trigger_common,
  output logic      [CH_COUNT-1:0] lamp_drive
);

  // ----------------------------------------------------------------
  // Trigger synchronisation and decoding
  // ----------------------------------------------------------------
  logic [CH_COUNT:0]   trig_sync;
  logic [CH_COUNT-1:0] trig_active;

  // Contacts pass the synchroniser before anything looks at them.
  input_sync #(.W(CH_COUNT + 1)) u_sync
  (
    .clock    (clock),
    .rst      (rst),
    .async_in ({lamp_trigger_common, lamp_trigger_in}),
    .sync_out (trig_sync)
  );

  // A contact pair reads high when open; open against common is active.
  // An open common contact activates every channel at once from one trigger.
  assign trig_active = trig_sync[CH_COUNT-1:0]
                     | {CH_COUNT{trig_sync[CH_COUNT]}};

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  lamp_cfg_type cfg_q;
  logic         wr_pend_q;
  logic [7:0]   wr_addr_q;
  logic [7:0]   rd_addr;
  logic         req;
  logic         rd_req;
  logic [31:0]  rd_data;
  logic [31:0]  cfg_word;

  assign req    = hsel & hready & htrans[1];
  assign rd_req = req & ~hwrite;
  assign rd_addr = haddr[7:0];

  // Pack the settings into the control word layout.
  assign cfg_word = {24'h000000, cfg_q.light_on, 2'b00, cfg_q.reversed, cfg_q.mode};

  // Read data selection; unmapped addresses read zero.
  assign rd_data = (rd_addr == CTRL_ADDR)   ? cfg_word :
                   (rd_addr == STATUS_ADDR) ? {24'h000000, lamp_drive, trig_active} :
                   32'h00000000;

  // Address phase capture and write data phase; zero wait states.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= req & hwrite;
      wr_addr_q <= haddr[7:0];
      if (rd_req)
      begin
        hrdata <= rd_data;
      end
    end
  end

  // Settings register; reset gives continuous mode, normal logic, all on.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cfg_q.mode     <= MODE_CONTINUOUS;
      cfg_q.reversed <= 1'b0;
      cfg_q.light_on <= LIGHT_RESET;
    end
    else if (wr_pend_q && wr_addr_q == CTRL_ADDR)
    begin
      cfg_q.mode     <= light_mode_type'(hwdata[MODE_BIT]);
      cfg_q.reversed <= hwdata[REVERSE_BIT];
      cfg_q.light_on <= hwdata[LIGHT_LSB +: CH_COUNT];
    end
  end

  // Bus answer is always ready and OKAY.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flash divider
  // ----------------------------------------------------------------
  logic [15:0] flash_cnt_q;
  logic        flash_q;
  logic        flash_tick;

  assign flash_tick = (flash_cnt_q == FLASH_HALF_MAX);

  // The flash phase toggles on each divider enable pulse.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      flash_cnt_q <= 16'h0000;
      flash_q     <= 1'b0;
    end
    else
    begin
      flash_cnt_q <= flash_tick ? 16'h0000 : flash_cnt_q + 16'h0001;
      if (flash_tick)
      begin
        flash_q <= ~flash_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lamp mapping, one channel per trigger input
  // ----------------------------------------------------------------
  logic [CH_COUNT-1:0] lamp_d;

  // Compute the lamp state of one channel from mode, polarity and trigger.
  function automatic logic lamp_state(input light_mode_type mode, input logic rev,
                                      input logic on, input logic act, input logic fl);
    logic r;
    r = 1'b0;
    if (mode == MODE_STROBE)
    begin
      r = (act ^ rev) & fl;
    end
    else if (!rev)
    begin
      r = on & act;
    end
    else
    begin
      r = on | ~act;
    end
    return r;
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++)
    begin : g_lamp
      // Channel ch is steered by trigger ch and by the common contact.
      assign lamp_d[ch] = lamp_state(cfg_q.mode, cfg_q.reversed, cfg_q.light_on[ch],
                                     trig_active[ch], flash_q);
    end
  endgenerate

  // Lamp outputs come straight from flip-flops.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lamp_drive <= '0;
    end
    else
    begin
      lamp_drive <= lamp_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_normal_cont;
    @(posedge clock) disable iff (rst)
    (cfg_q.mode == MODE_CONTINUOUS && !cfg_q.reversed) |=>
      lamp_drive == ($past(cfg_q.light_on) & $past(trig_active));
  endproperty
  a_normal_cont: assert property (p_normal_cont) else $error("normal lamp wrong");

  property p_rev_lit;
    @(posedge clock) disable iff (rst)
    (cfg_q.mode == MODE_CONTINUOUS && cfg_q.reversed && cfg_q.light_on[0])
      ##1 (cfg_q.mode == MODE_CONTINUOUS && cfg_q.reversed) |-> lamp_drive[0];
  endproperty
  a_rev_lit: assert property (p_rev_lit) else $error("reversed on lamp dark");

  property p_off_normal;
    @(posedge clock) disable iff (rst)
    (cfg_q.mode == MODE_CONTINUOUS && !cfg_q.reversed && !cfg_q.light_on[1]) |=> !lamp_drive[1];
  endproperty
  a_off_normal: assert property (p_off_normal) else $error("off lamp lit");

  property p_strobe_dark;
    @(posedge clock) disable iff (rst)
    (cfg_q.mode == MODE_STROBE && (trig_active[2] == cfg_q.reversed)) |=> !lamp_drive[2];
  endproperty
  a_strobe_dark: assert property (p_strobe_dark) else $error("strobe lamp lit");

  property p_sync_delay;
    @(posedge clock) disable iff (rst)
    ##2 1'b1 |-> trig_active[0] ==
      ($past(lamp_trigger_in[0], 2) | $past(lamp_trigger_common, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong");

  property p_ready;
    @(posedge clock) disable iff (rst) hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready");

  property p_default;
    @(posedge clock) rst |=> !cfg_q.reversed && cfg_q.mode == MODE_CONTINUOUS;
  endproperty
  a_default: assert property (p_default) else $error("bad reset default");

  property p_flash_period;
    @(posedge clock) disable iff (rst)
    flash_tick |=> flash_cnt_q == 16'h0000 && flash_q != $past(flash_q);
  endproperty
  a_flash_period: assert property (p_flash_period) else $error("divider wrap wrong");

  c_strobe: cover property (@(posedge clock) cfg_q.mode == MODE_STROBE && lamp_drive[0]);
  c_rev:    cover property (@(posedge clock) cfg_q.reversed && lamp_drive[3]);
  c_write:  cover property (@(posedge clock) wr_pend_q && wr_addr_q == CTRL_ADDR);

endmodule

/* logic/light_trigger_pkg.sv */
// Package for the lamp trigger controller: register map, fields, resets and timing.
// Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
package light_trigger_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  // ----------------------------------------------------------------
  // Control field positions and reset values
  // ----------------------------------------------------------------
  localparam int         MODE_BIT     = 0;
  localparam int         REVERSE_BIT  = 1;
  localparam int         LIGHT_LSB    = 4;
  localparam int         CH_COUNT     = 4;
  localparam logic [3:0] LIGHT_RESET  = 4'hF;

  // ----------------------------------------------------------------
  // Flash timing: the lamp toggles every half period
  // ----------------------------------------------------------------
  localparam int          CLOCK_HZ       = 20000000;
  localparam int          FLASH_HALF_US  = 500;
  localparam int          FLASH_HALF_CYC = FLASH_HALF_US * (CLOCK_HZ / 1000000);
  localparam logic [15:0] FLASH_HALF_MAX = 16'(FLASH_HALF_CYC - 1);

  typedef enum logic { MODE_CONTINUOUS, MODE_STROBE } light_mode_type;

  // Settings that software writes.
  typedef struct packed {
    light_mode_type      mode;
    logic                reversed;
    logic [CH_COUNT-1:0] light_on;
  } lamp_cfg_type;

endpackage

/* testbench/camera_strobe_model.sv */
// Camera strobe output model that drives the common trigger contact.
// Assumes the bench pulses frame_start_event for one clock at a time.
`timescale 1ns/1ps
module camera_strobe_model
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       frame_start_event,
  input  wire logic       pulse_length_policy,
  input  wire logic [7:0] pulse_start_delay,
  input  wire logic [7:0] pulse_length,
  input  wire logic [7:0] exposure_len,
  input  wire logic       output_polarity,
  output logic            camera_output_one
);
  logic [8:0] age_q;
  logic       pulse_on;
  // Counts clocks since the frame started and parks at the top.
  always_ff @(posedge clock)
  begin
    if (rst)
      age_q <= 9'h1FF;
    else if (frame_start_event)
      age_q <= 9'h000;
    else if (age_q != 9'h1FF)
      age_q <= age_q + 9'h001;
  end
  // Timed pulse after a delay, or a copy of the exposure window.
  assign pulse_on = pulse_length_policy ?
    (age_q >= {1'b0, pulse_start_delay} &&
     age_q < {1'b0, pulse_start_delay} + {1'b0, pulse_length}) :
    (age_q < {1'b0, exposure_len});
  // Negative polarity keeps the line high between pulses.
  assign camera_output_one = pulse_on ^ output_polarity;
endmodule

/* testbench/tb.sv */
// Self-checking bench for the lamp trigger controller.
// Assumes the design answers the bus with zero wait states.
`timescale 1ns/1ps
module tb;
  import light_trigger_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hsel = 1'b0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  trig = 4'h0;
  logic        common_b = 1'b0;
  logic        use_cam = 1'b0;
  logic        cam;
  logic        fev = 1'b0;
  logic        policy = 1'b0;
  logic [3:0]  lamp;
  logic [31:0] rd_v, rv, exp_v, seen;
  logic [31:0] exp_q[$];
  event        got;
  int          err_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          seed = 89968;
  int          n;
  assign hready = hreadyout;
  // Clock at 20 MHz.
  always #25 clock = ~clock;
  light_trigger_controller dut_u (.clock(clock), .rst(rst), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lamp_trigger_in(trig),
    .lamp_trigger_common(use_cam ? cam : common_b), .lamp_drive(lamp));
  camera_strobe_model cam_u (.clock(clock), .rst(rst), .frame_start_event(fev),
    .pulse_length_policy(policy), .pulse_start_delay(8'h0A), .pulse_length(8'h64),
    .exposure_len(8'h28), .output_polarity(1'b1), .camera_output_one(cam));
  // Ends the run with the verdict.
  task results;
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Files an expectation and hands the observed value to the monitor.
  task note(input logic [31:0] e, input logic [31:0] v);
    exp_q.push_back(e);
    seen = v;
    -> got;
    #1;
  endtask
  // Monitor takes the oldest expectation for each observed result.
  always @(got)
  begin
    exp_v = exp_q.pop_front();
    n_tests++;
    if (seen !== exp_v)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp_v);
    end
  end
  // One single-word transfer; entered just after a rising edge.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd_v);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd_v);
    note(e, rd_v);
  endtask
  // Sets the contacts and lets them pass the synchroniser.
  task drive(input logic [3:0] t, input logic c);
    trig <= t;
    common_b <= c;
    repeat (5) @(posedge clock);
  endtask
  task count_lit(input int c);
    n = 0;
    repeat (c)
    begin
      @(posedge clock);
      if (lamp === 4'hF) n++;
      else if (lamp !== 4'h0) n--;
    end
  endtask
  // Hang guard.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      err_count++;
      results;
    end
  end
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    note(32'h0, {28'h0, lamp});
    note(32'h2, {30'h0, hreadyout, hresp});
    rd_chk(CTRL_ADDR, 32'h000000F0);
    rd_chk(8'h08, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(CTRL_ADDR, {24'h0, {4{i[1]}}, 2'h0, i[0], 1'b0});
      drive({4{i[2]}}, i[2]);
      rv = {28'h0, i[0] ? {4{i[1] | ~i[2]}} : {4{i[1] & i[2]}}};
      note(rv, {28'h0, lamp});
    end
    rd_chk(STATUS_ADDR, 32'h000000FF);
    repeat (6)
    begin
      rv = $random(seed);
      wr(CTRL_ADDR, {24'h0, rv[7:4], 4'h0});
      drive(rv[3:0], 1'b0);
      note({28'h0, rv[7:4] & rv[3:0]}, {28'h0, lamp});
    end
    wr(CTRL_ADDR, 32'h000000F0);
    drive(4'h0, 1'b1);
    note(32'hF, {28'h0, lamp});
    for (int i = 0; i < 4; i++)
    begin
      wr(CTRL_ADDR, {24'h0, 4'hF, 2'h0, i[0], 1'b1});
      drive({4{i[1]}}, i[1]);
      count_lit(2 * FLASH_HALF_CYC);
      note((i[0] ^ i[1]) ? FLASH_HALF_CYC : 0, n);
    end
    wr(CTRL_ADDR, 32'h00000002);
    use_cam <= 1'b1;
    drive(4'h0, 1'b0);
    for (int p = 0; p < 2; p++)
    begin
      policy <= p[0];
      fev <= 1'b1;
      @(posedge clock);
      fev <= 1'b0;
      count_lit(200);
      note(p ? 100 : 40, n);
    end
    results;
  end
endmodule
